// *** hw/tva_adc_path.v ***
`timescale 1ns/100ps
`include "tva_defs.vh"
// Contract
// R01 - Samples are taken on a falling edge and appear on a rising edge 2.5 cycles later. The code delays or drops them while sink_ready_in is low.
// R02 - Each code is 8 bits wide, bit 0 least significant and bit 7 most significant.
// R03 - Red, green and blue conversions drive their own separate output buses.
// R04 - Luma and colour-difference inputs use the same buses with the same timing.
// R05 - The dither counter advances once per line-sync pulse. The code ignores a line-sync rise in the same cycle as a frame-sync rise.
// R06 - Clamp restoration is active only while line-sync pulses are present, ahead of conversion.
// R08 - The clamp-level select is decoded as low, high or open.
// R09 - The dither counter clears after every second frame-sync pulse and stops while frame sync is low.
// R10 - Outputs are enabled while the active-low select is low and released while it is high.
// R11 - Clamp levels are 16/16/16, green 16 with red/blue 128, or green 64 with red/blue 128.
// R12 - The dither offset is subtracted from each code by a binary adder, shifting the range by one. The code leaves code 0x00 unchanged.
// R13 - The pipeline takes a sample every falling edge and updates all buses together on rising edges.
module tva_adc_path (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire [7:0] red_analog_in,
  input  wire [7:0] green_analog_in,
  input  wire [7:0] blue_analog_in,
  input  wire       line_sync_in,
  input  wire       frame_sync_in,
  input  wire       mode_low_in,
  input  wire       mode_high_in,
  input  wire       out_sel_n_in,
  input  wire       sink_ready_in,
  output wire       code_valid_out,
  output wire [7:0] red_code_out,
  output wire [7:0] green_code_out,
  output wire [7:0] blue_code_out,
  output wire       code_oe_out,
  output wire       clamp_active_out,
  output reg  [7:0] red_clamp_out,
  output reg  [7:0] green_clamp_out,
  output reg  [7:0] blue_clamp_out,
  output wire [1:0] dither_state_out
);
  localparam [2:0] MODE_LOW  = 3'b001;
  localparam [2:0] MODE_HIGH = 3'b010;
  localparam [2:0] MODE_OPEN = 3'b100;

  // Falling-edge sample stage, rising-edge stages and control signals
  reg  [7:0] red_smp_ff;
  reg  [7:0] green_smp_ff;
  reg  [7:0] blue_smp_ff;
  reg  [7:0] red_p1_ff;
  reg  [7:0] green_p1_ff;
  reg  [7:0] blue_p1_ff;
  reg  [7:0] red_p2_ff;
  reg  [7:0] green_p2_ff;
  reg  [7:0] blue_p2_ff;
  reg  [1:0] dith_ff;
  reg  [1:0] nxt_dith;
  reg        line_d_ff;
  reg        frame_d_ff;
  reg        frame_cnt_ff;
  reg        nxt_frame_cnt;
  reg  [2:0] mode_ff;
  reg  [2:0] nxt_mode;
  wire       line_rise;
  wire       frame_rise;
  wire       offs;
  wire       buf_ready;
  wire [23:0] buf_data;

  // Dither correction adder
  function [7:0] tva_correct;
    input [7:0] code;
    input       off;
    begin
      if (off && code != `TVA_CODE_ZERO)
        tva_correct = code - {7'h00, off};
      else
        tva_correct = code;
    end
  endfunction

  // R01 sample on falling edge
  // R13 one sample each fall
  always @(negedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      red_smp_ff   <= `TVA_CODE_ZERO;
      green_smp_ff <= `TVA_CODE_ZERO;
      blue_smp_ff  <= `TVA_CODE_ZERO;
    end
    else
    begin
      red_smp_ff   <= red_analog_in;
      green_smp_ff <= green_analog_in;
      blue_smp_ff  <= blue_analog_in;
    end
  end

  assign line_rise  = line_sync_in & ~line_d_ff;
  assign frame_rise = frame_sync_in & ~frame_d_ff;
  assign offs       = dith_ff[0];

  always @*
  begin
    nxt_dith      = dith_ff;
    nxt_frame_cnt = frame_cnt_ff;
    // R09 frame clear, hold
    if (!frame_sync_in)
      nxt_dith = dith_ff;
    else if (frame_rise)
    begin
      nxt_frame_cnt = ~frame_cnt_ff;
      if (frame_cnt_ff)
        nxt_dith = `TVA_DITH_ZERO;
    end
    // R05 advance per line
    else if (line_rise)
      nxt_dith = dith_ff + `TVA_DITH_ONE;
  end

  // R08 three-state decode
  always @*
  begin
    case ({mode_high_in, mode_low_in})
      2'b01:   nxt_mode = MODE_LOW;
      2'b10:   nxt_mode = MODE_HIGH;
      default: nxt_mode = MODE_OPEN;
    endcase
  end

  // R11 clamp level table
  always @*
  begin
    case (mode_ff)
      MODE_LOW:
      begin
        red_clamp_out   = `TVA_CLAMP_16;
        green_clamp_out = `TVA_CLAMP_16;
        blue_clamp_out  = `TVA_CLAMP_16;
      end
      MODE_HIGH:
      begin
        red_clamp_out   = `TVA_CLAMP_128;
        green_clamp_out = `TVA_CLAMP_16;
        blue_clamp_out  = `TVA_CLAMP_128;
      end
      default:
      begin
        red_clamp_out   = `TVA_CLAMP_128;
        green_clamp_out = `TVA_CLAMP_64;
        blue_clamp_out  = `TVA_CLAMP_128;
      end
    endcase
  end

  // R06 clamp only during sync
  assign clamp_active_out = line_sync_in;

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      red_p1_ff    <= `TVA_CODE_ZERO;
      green_p1_ff  <= `TVA_CODE_ZERO;
      blue_p1_ff   <= `TVA_CODE_ZERO;
      red_p2_ff    <= `TVA_CODE_ZERO;
      green_p2_ff  <= `TVA_CODE_ZERO;
      blue_p2_ff   <= `TVA_CODE_ZERO;
      dith_ff      <= `TVA_DITH_ZERO;
      line_d_ff    <= 1'b0;
      frame_d_ff   <= 1'b0;
      frame_cnt_ff <= `TVA_FRAME_ZERO;
      mode_ff      <= MODE_LOW;
    end
    else
    begin
      // R01 second stage
      red_p1_ff    <= red_smp_ff;
      green_p1_ff  <= green_smp_ff;
      blue_p1_ff   <= blue_smp_ff;
      // R12 subtract dither offset
      red_p2_ff    <= tva_correct(red_p1_ff, offs);
      green_p2_ff  <= tva_correct(green_p1_ff, offs);
      blue_p2_ff   <= tva_correct(blue_p1_ff, offs);
      dith_ff      <= nxt_dith;
      line_d_ff    <= line_sync_in;
      frame_d_ff   <= frame_sync_in;
      frame_cnt_ff <= nxt_frame_cnt;
      mode_ff      <= nxt_mode;
    end
  end

  // R03 separate buses via buffer
  // R04 same path any format
  tva_buf2 #(
    .W (24)
  ) u_buf (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (1'b1),
    .in_ready_out  (buf_ready),
    .in_data_in    ({red_p2_ff, green_p2_ff, blue_p2_ff}),
    .out_valid_out (code_valid_out),
    .out_ready_in  (sink_ready_in),
    .out_data_out  (buf_data)
  );

  // R02 bit 7 is MSB
  assign red_code_out   = buf_data[23:16];
  assign green_code_out = buf_data[15:8];
  assign blue_code_out  = buf_data[7:0];
  // R10 active-low output select
  assign code_oe_out    = ~out_sel_n_in;
  assign dither_state_out = dith_ff;
endmodule // tva_adc_path

// *** hw/tva_buf2.v ***
`timescale 1ns/100ps
// Two-entry skid buffer
module tva_buf2 #(
  parameter W = 24
) (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem_ff [0:1];
  reg         wr_ptr_ff;
  reg         rd_ptr_ff;
  reg [1:0]   cnt_ff;
  wire        push;
  wire        pop;

  assign in_ready_out  = (cnt_ff != 2'h2);
  assign out_valid_out = (cnt_ff != 2'h0);
  assign out_data_out  = mem_ff[rd_ptr_ff];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
      mem_ff[0] <= {W{1'b0}};
      mem_ff[1] <= {W{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_ff[wr_ptr_ff] <= in_data_in;
        wr_ptr_ff         <= ~wr_ptr_ff;
      end
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      if (push & ~pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop & ~push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end
endmodule // tva_buf2

// *** hw/tva_defs.vh ***
`ifndef TVA_DEFS_VH
`define TVA_DEFS_VH
`define TVA_CODE_W      8
`define TVA_CODE_ZERO   8'h00
`define TVA_CODE_MAX    8'hFF
`define TVA_DITH_W      2
`define TVA_DITH_ZERO   2'h0
`define TVA_DITH_ONE    2'h1
`define TVA_FRAME_ZERO  1'h0
`define TVA_CLAMP_W     8
`define TVA_CLAMP_16    8'h10
`define TVA_CLAMP_64    8'h40
`define TVA_CLAMP_128   8'h80
`define TVA_BUF_DEPTH   2
`endif

// *** tb/tva_adc_path_sva.sv ***
`timescale 1ns/100ps
`include "tva_defs.vh"
module tva_adc_path_sva (
  input wire       clk_in,
  input wire       rst_in,
  input wire       line_sync_in,
  input wire       frame_sync_in,
  input wire       mode_low_in,
  input wire       mode_high_in,
  input wire       out_sel_n_in,
  input wire       sink_ready_in,
  input wire       code_valid_out,
  input wire [7:0] red_code_out,
  input wire [7:0] green_code_out,
  input wire [7:0] blue_code_out,
  input wire       code_oe_out,
  input wire       clamp_active_out,
  input wire [7:0] red_clamp_out,
  input wire [7:0] green_clamp_out,
  input wire [7:0] blue_clamp_out,
  input wire [1:0] dither_state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence quiet_s; (!line_sync_in && frame_sync_in) [*4]; endsequence
  sequence stall_s; code_valid_out && !sink_ready_in; endsequence
  oe_follow_a: assert property (code_oe_out == !out_sel_n_in) else $error("oe wrong");
  clamp_gate_a: assert property (clamp_active_out == line_sync_in) else $error("clamp gate wrong");
  dither_idle_a: assert property (quiet_s |=> $stable(dither_state_out)) else $error("dither moved");
  dither_stop_a: assert property (!frame_sync_in [*3] |=> $stable(dither_state_out)) else $error("dither run");
  word_hold_a: assert property (stall_s |=> code_valid_out && $stable({red_code_out, green_code_out, blue_code_out}))
    else $error("word lost");
  clamp_low_a: assert property ((mode_low_in && !mode_high_in) [*3] |-> {red_clamp_out, green_clamp_out,
    blue_clamp_out} == {`TVA_CLAMP_16, `TVA_CLAMP_16, `TVA_CLAMP_16}) else $error("low clamp");
  clamp_high_a: assert property ((!mode_low_in && mode_high_in) [*3] |-> {red_clamp_out, green_clamp_out,
    blue_clamp_out} == {`TVA_CLAMP_128, `TVA_CLAMP_16, `TVA_CLAMP_128}) else $error("high clamp");
  clamp_open_a: assert property ((mode_low_in == mode_high_in) [*3] |-> {red_clamp_out, green_clamp_out,
    blue_clamp_out} == {`TVA_CLAMP_128, `TVA_CLAMP_64, `TVA_CLAMP_128}) else $error("open clamp");
endmodule // tva_adc_path_sva
bind tva_adc_path tva_adc_path_sva chk_u (.clk_in, .rst_in, .line_sync_in, .frame_sync_in, .mode_low_in,
  .mode_high_in, .out_sel_n_in, .sink_ready_in, .code_valid_out, .red_code_out, .green_code_out, .blue_code_out,
  .code_oe_out, .clamp_active_out, .red_clamp_out, .green_clamp_out, .blue_clamp_out, .dither_state_out);

// *** tb/tva_adc_path_tb_top.sv ***
`timescale 1ns/100ps
module tva_adc_path_tb_top;
  reg        clk_in = 1'b0;
  reg        rst_in = 1'b1;
  reg  [7:0] r = 8'h00, g = 8'h00, b = 8'h00;
  reg        line = 1'b0, frame = 1'b0, ml = 1'b1, mh = 1'b0, sel_n = 1'b0, stall = 1'b0;
  reg  [1:0] exp_d = 2'h0;
  wire       ready, valid, oe, act;
  wire [7:0] ro, go, bo, rc, gc, bc;
  wire [1:0] dith;
  integer    n_errors = 0, checked = 0, cycles = 0, i;
  always #5 clk_in = ~clk_in;
  tva_sink_model sink_u (.clk_in(clk_in), .stall_in(stall), .ready_out(ready));
  tva_adc_path dut_u (.clk_in(clk_in), .rst_in(rst_in), .red_analog_in(r), .green_analog_in(g),
    .blue_analog_in(b), .line_sync_in(line), .frame_sync_in(frame), .mode_low_in(ml), .mode_high_in(mh),
    .out_sel_n_in(sel_n), .sink_ready_in(ready), .code_valid_out(valid), .red_code_out(ro),
    .green_code_out(go), .blue_code_out(bo), .code_oe_out(oe), .clamp_active_out(act), .red_clamp_out(rc),
    .green_clamp_out(gc), .blue_clamp_out(bc), .dither_state_out(dith));
  task wrap_up;
    begin
      if (n_errors == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  task chk(input [23:0] got, input [23:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  function [7:0] sub(input [7:0] c);
    sub = (c != 8'h00 && exp_d[0]) ? c - 8'h01 : c;
  endfunction
  task put(input [23:0] w);
    begin
      @(negedge clk_in);
      {r, g, b} <= w;
    end
  endtask
  task pulse_line;
    begin
      @(negedge clk_in) line <= 1'b1;
      @(negedge clk_in) line <= 1'b0;
      repeat (3) @(negedge clk_in);
      if (frame)
        exp_d = exp_d + 2'h1;
      chk({22'h0, dith}, {22'h0, exp_d});
    end
  endtask
  task t_latency;
    reg [23:0] tab [0:2];
    begin
      tab[0] = 24'h017FFF;
      tab[1] = 24'hFF0080;
      tab[2] = 24'h80C33C;
      for (i = 0; i < 3; i = i + 1)
      begin
        put(tab[i]);
        // Half a cycle before the new code is due
        repeat (3) @(negedge clk_in);
        chk({ro, go, bo}, i == 0 ? 24'h000000 : tab[i - 1]);
        @(negedge clk_in);
        chk({ro, go, bo}, tab[i]);
      end
    end
  endtask
  task t_dither;
    begin
      put(24'h800001);
      pulse_line;
      chk({ro, go, bo}, {sub(8'h80), sub(8'h00), sub(8'h01)});
      pulse_line;
      chk({ro, go, bo}, 24'h800001);
      frame <= 1'b0;
      pulse_line;
      frame <= 1'b1;
      exp_d = 2'h0;
      repeat (4) @(negedge clk_in);
      chk({22'h0, dith}, 24'h0);
      pulse_line;
      // First frame pulse of a pair keeps the count
      @(negedge clk_in) frame <= 1'b0;
      @(negedge clk_in) frame <= 1'b1;
      repeat (2) @(negedge clk_in);
      chk({22'h0, dith}, {22'h0, exp_d});
      @(negedge clk_in) frame <= 1'b0;
      @(negedge clk_in) frame <= 1'b1;
      exp_d = 2'h0;
      repeat (2) @(negedge clk_in);
      chk({22'h0, dith}, 24'h0);
    end
  endtask
  task t_mode;
    reg [23:0] tab [0:2];
    begin
      tab[0] = 24'h101010;
      tab[1] = 24'h801080;
      tab[2] = 24'h804080;
      for (i = 0; i < 3; i = i + 1)
      begin
        @(negedge clk_in) {ml, mh} <= (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b00;
        repeat (4) @(negedge clk_in);
        chk({rc, gc, bc}, tab[i]);
      end
      @(negedge clk_in) {line, sel_n} <= 2'b11;
      #1 chk({act, oe}, 2'b10);
      @(negedge clk_in) {line, sel_n} <= 2'b00;
      exp_d = exp_d + 2'h1;
      #1 chk({act, oe}, 2'b01);
    end
  endtask
  task t_stall;
    begin
      @(negedge clk_in) stall <= 1'b1;
      put(24'h44FE02);
      repeat (8) @(negedge clk_in);
      chk({23'h0, valid}, 24'h1);
      // Head word stands through the stall
      chk({ro, go, bo}, {sub(8'h80), sub(8'h00), sub(8'h01)});
      stall <= 1'b0;
      repeat (8) @(negedge clk_in);
      chk({ro, go, bo}, {sub(8'h44), sub(8'hFE), sub(8'h02)});
    end
  endtask
  initial
  begin
    repeat (16) @(negedge clk_in);
    rst_in <= 1'b0;
    frame <= 1'b1;
    repeat (8) @(negedge clk_in);
    t_latency;
    t_dither;
    t_mode;
    t_stall;
    wrap_up;
  end
endmodule // tva_adc_path_tb_top

// *** tb/tva_sink_model.sv ***
`timescale 1ns/100ps
module tva_sink_model (
  input  wire clk_in,
  input  wire stall_in,
  output reg  ready_out
);
  initial ready_out = 1'b1;
  always @(negedge clk_in) ready_out <= !stall_in;
endmodule // tva_sink_model
